// ===== core_regs_pkg.sv
package core_regs_pkg;

    // Register addresses in the special-function space, same on every page
    localparam logic [7:0] STACK_TOP_POINTER_ADDR = 8'h81;
    localparam logic [7:0] DATA_POINTER_LOW_ADDR = 8'h82;
    localparam logic [7:0] DATA_POINTER_HIGH_ADDR = 8'h83;
    localparam logic [7:0] PROGRAM_STATUS_WORD_ADDR = 8'hd0;
    localparam logic [7:0] PRIMARY_ACCUMULATOR_ADDR = 8'he0;
    localparam logic [7:0] SECONDARY_ACCUMULATOR_ADDR = 8'hf0;

    // Reset values, and the value read at unmapped addresses
    localparam logic [7:0] STACK_TOP_POINTER_RST = 8'h07;
    localparam logic [7:0] DATA_POINTER_LOW_RST = 8'h00;
    localparam logic [7:0] DATA_POINTER_HIGH_RST = 8'h00;
    localparam logic [7:0] PRIMARY_ACCUMULATOR_RST = 8'h00;
    localparam logic [7:0] SECONDARY_ACCUMULATOR_RST = 8'h00;
    localparam logic FLAG_RST = 1'b0;
    localparam logic [1:0] BANK_SELECT_RST = 2'h0;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // Status word field positions
    localparam int CARRY_FLAG_BIT = 7;
    localparam int HALF_CARRY_FLAG_BIT = 6;
    localparam int USER_FLAG_ZERO_BIT = 5;
    localparam int BANK_SELECT_HI = 4;
    localparam int BANK_SELECT_LO = 3;

    // Bit address: byte address in [7:3], bit position in [2:0]
    localparam logic [2:0] BIT_BYTE_ALIGN = 3'h0;

    typedef enum logic [2:0] {
        ALU_NONE = 3'b000,
        ALU_ADD = 3'b001,
        ALU_ADDC = 3'b010,
        ALU_SUBB = 3'b011,
        ALU_MUL = 3'b100
    } alu_op_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } sfr_req_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic val;
    } bit_req_t;

    typedef struct packed {
        alu_op_t op;
        logic [7:0] operand;
    } alu_req_t;

    typedef struct packed {
        logic carry_flag;
        logic half_carry_flag;
        logic user_flag_zero;
        logic [1:0] register_bank_select;
    } status_t;

    typedef struct packed {
        logic [7:0] stack_top_pointer;
        logic [7:0] pointer_low_byte;
        logic [7:0] pointer_high_byte;
        status_t status_word;
        logic [7:0] primary_accumulator;
        logic [7:0] secondary_accumulator;
        logic [7:0] rdata;
        logic [7:0] push_addr;
        logic [15:0] flash_addr;
        logic [15:0] external_data_ram_addr;
    } core_state_t;

endpackage

// ===== arith_flag_unit.sv
// Adder and subtractor with carry and half-carry generation; the multiplier clears both flags
module arith_flag_unit (
    input wire logic [7:0] lhs,
    input wire logic [7:0] rhs,
    input wire logic carry_in,
    input wire core_regs_pkg::alu_op_t op,
    output logic [7:0] res_lo,
    output logic [7:0] res_hi,
    output logic carry_out,
    output logic half_carry_out
);
    logic [8:0] wide;
    logic [4:0] nib;
    logic [15:0] prod;
    logic cin;

    // Carry in only for the with-carry forms
    always_comb begin
        cin = (op == core_regs_pkg::ALU_ADDC || op == core_regs_pkg::ALU_SUBB)
            ? carry_in : 1'b0;
        wide = 9'h000;
        nib = 5'h00;
        prod = 16'h0000;
        res_lo = 8'h00;
        res_hi = 8'h00;
        carry_out = 1'b0;
        half_carry_out = 1'b0;
        case (op)
            core_regs_pkg::ALU_ADD, core_regs_pkg::ALU_ADDC: begin
                wide = {1'b0, lhs} + {1'b0, rhs} + {8'h00, cin};
                nib = {1'b0, lhs[3:0]} + {1'b0, rhs[3:0]} + {4'h0, cin};
                res_lo = wide[7:0];
                carry_out = wide[8];
                half_carry_out = nib[4];
            end
            core_regs_pkg::ALU_SUBB: begin
                // Top bit of the wide difference is the borrow
                wide = {1'b0, lhs} - {1'b0, rhs} - {8'h00, cin};
                nib = {1'b0, lhs[3:0]} - {1'b0, rhs[3:0]} - {4'h0, cin};
                res_lo = wide[7:0];
                carry_out = wide[8];
                half_carry_out = nib[4];
            end
            core_regs_pkg::ALU_MUL: begin
                // Other arithmetic clears both flags
                prod = lhs * rhs;
                res_lo = prod[7:0];
                res_hi = prod[15:8];
            end
            default: begin
                res_lo = lhs;
            end
        endcase
    end
endmodule

// ===== cpu_core_register_set.sv
module cpu_core_register_set (
    input wire logic ref_clk,
    input wire logic reset,
    input wire core_regs_pkg::sfr_req_t sfr_req,
    input wire core_regs_pkg::bit_req_t bit_req,
    input wire core_regs_pkg::alu_req_t alu_req,
    input wire logic push_req,
    input wire logic pop_req,
    output logic [7:0] sfr_rdata,
    output logic [7:0] stack_top_pointer,
    output logic [7:0] push_addr,
    output logic [15:0] data_pointer_16,
    output logic [15:0] flash_addr,
    output logic [15:0] external_data_ram_addr,
    output logic [7:0] primary_accumulator,
    output logic [7:0] secondary_accumulator,
    output core_regs_pkg::status_t program_status_word
);
    core_regs_pkg::core_state_t s_q, s_d;
    logic [7:0] alu_lo, alu_hi;
    logic alu_carry, alu_half;
    logic [7:0] wr_addr, wr_data;
    logic wr_en;
    logic [7:0] stack_inc;

    // Byte view of the register file; the page never enters the decode
    function automatic logic [7:0] read_byte(
        input core_regs_pkg::core_state_t st,
        input logic [7:0] addr
    );
        logic [7:0] v;
        v = core_regs_pkg::READ_UNMAPPED;
        case (addr)
            core_regs_pkg::STACK_TOP_POINTER_ADDR: v = st.stack_top_pointer;
            core_regs_pkg::DATA_POINTER_LOW_ADDR: v = st.pointer_low_byte;
            core_regs_pkg::DATA_POINTER_HIGH_ADDR: v = st.pointer_high_byte;
            core_regs_pkg::PROGRAM_STATUS_WORD_ADDR:
                v = {st.status_word, 3'h0};
            core_regs_pkg::PRIMARY_ACCUMULATOR_ADDR:
                v = st.primary_accumulator;
            core_regs_pkg::SECONDARY_ACCUMULATOR_ADDR:
                v = st.secondary_accumulator;
            default: v = core_regs_pkg::READ_UNMAPPED;
        endcase
        return v;
    endfunction

    arith_flag_unit alu (
        .lhs(s_q.primary_accumulator),
        .rhs(alu_req.operand),
        .carry_in(s_q.status_word.carry_flag),
        .op(alu_req.op),
        .res_lo(alu_lo),
        .res_hi(alu_hi),
        .carry_out(alu_carry),
        .half_carry_out(alu_half)
    );

    // Next state: datapath first, software writes last so they win
    always_comb begin
        s_d = s_q;
        stack_inc = s_q.stack_top_pointer + 8'h01;
        wr_en = sfr_req.wr;
        wr_addr = sfr_req.addr;
        wr_data = sfr_req.wdata;
        // Bit writes become read-modify-write of the owning byte
        if (!sfr_req.wr && bit_req.wr) begin
            wr_en = 1'b1;
            wr_addr = {bit_req.addr[7:3], core_regs_pkg::BIT_BYTE_ALIGN};
            wr_data = read_byte(s_q, wr_addr);
            wr_data[bit_req.addr[2:0]] = bit_req.val;
        end
        // Arithmetic results and flags
        if (alu_req.op != core_regs_pkg::ALU_NONE) begin
            s_d.primary_accumulator = alu_lo;
            s_d.status_word.carry_flag = alu_carry;
            s_d.status_word.half_carry_flag = alu_half;
            if (alu_req.op == core_regs_pkg::ALU_MUL) begin
                s_d.secondary_accumulator = alu_hi;
            end
        end
        // Pre-increment: the byte lands at the new top
        if (push_req) begin
            s_d.stack_top_pointer = stack_inc;
            s_d.push_addr = stack_inc;
        end else if (pop_req) begin
            s_d.stack_top_pointer = s_q.stack_top_pointer - 8'h01;
        end
        if (wr_en) begin
            case (wr_addr)
                core_regs_pkg::STACK_TOP_POINTER_ADDR:
                    s_d.stack_top_pointer = wr_data;
                core_regs_pkg::DATA_POINTER_LOW_ADDR:
                    s_d.pointer_low_byte = wr_data;
                core_regs_pkg::DATA_POINTER_HIGH_ADDR:
                    s_d.pointer_high_byte = wr_data;
                core_regs_pkg::PROGRAM_STATUS_WORD_ADDR: begin
                    s_d.status_word.carry_flag =
                        wr_data[core_regs_pkg::CARRY_FLAG_BIT];
                    s_d.status_word.half_carry_flag =
                        wr_data[core_regs_pkg::HALF_CARRY_FLAG_BIT];
                    s_d.status_word.user_flag_zero =
                        wr_data[core_regs_pkg::USER_FLAG_ZERO_BIT];
                    s_d.status_word.register_bank_select = wr_data[
                        core_regs_pkg::BANK_SELECT_HI:
                        core_regs_pkg::BANK_SELECT_LO];
                end
                core_regs_pkg::PRIMARY_ACCUMULATOR_ADDR:
                    s_d.primary_accumulator = wr_data;
                core_regs_pkg::SECONDARY_ACCUMULATOR_ADDR:
                    s_d.secondary_accumulator = wr_data;
                default: ;
            endcase
        end
        // Read data holds until the next read strobe
        if (sfr_req.rd) begin
            s_d.rdata = read_byte(s_q, sfr_req.addr);
        end
        // Indirect addresses follow the pointer one cycle behind
        s_d.external_data_ram_addr =
            {s_q.pointer_high_byte, s_q.pointer_low_byte};
        s_d.flash_addr = {s_q.pointer_high_byte, s_q.pointer_low_byte}
            + {8'h00, s_q.primary_accumulator};
    end

    // All state in one register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_q <= '0;
            s_q.stack_top_pointer <=
                core_regs_pkg::STACK_TOP_POINTER_RST;
            s_q.pointer_low_byte <= core_regs_pkg::DATA_POINTER_LOW_RST;
            s_q.pointer_high_byte <= core_regs_pkg::DATA_POINTER_HIGH_RST;
            s_q.status_word <= {{3{core_regs_pkg::FLAG_RST}},
                core_regs_pkg::BANK_SELECT_RST};
            s_q.primary_accumulator <=
                core_regs_pkg::PRIMARY_ACCUMULATOR_RST;
            s_q.secondary_accumulator <=
                core_regs_pkg::SECONDARY_ACCUMULATOR_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign sfr_rdata = s_q.rdata;
    assign stack_top_pointer = s_q.stack_top_pointer;
    assign push_addr = s_q.push_addr;
    assign data_pointer_16 = {s_q.pointer_high_byte, s_q.pointer_low_byte};
    assign flash_addr = s_q.flash_addr;
    assign external_data_ram_addr = s_q.external_data_ram_addr;
    assign primary_accumulator = s_q.primary_accumulator;
    assign secondary_accumulator = s_q.secondary_accumulator;
    assign program_status_word = s_q.status_word;

    stack_reset_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        $fell(reset)
        |-> stack_top_pointer == core_regs_pkg::STACK_TOP_POINTER_RST)
        else $error("stack pointer not 0x07 after reset");

    push_incr_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        push_req && !sfr_req.wr && !bit_req.wr
        |=> stack_top_pointer == $past(stack_top_pointer) + 8'h01
            && push_addr == stack_top_pointer)
        else $error("push did not pre-increment stack pointer");

    pointer_form_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        sfr_req.wr && sfr_req.addr == core_regs_pkg::DATA_POINTER_HIGH_ADDR
        |=> data_pointer_16[15:8] == $past(sfr_req.wdata))
        else $error("pointer high byte not written");

    ext_addr_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        !$fell(reset) |-> ##1 external_data_ram_addr == $past(data_pointer_16)
            && flash_addr == $past(data_pointer_16)
                + {8'h00, $past(primary_accumulator)})
        else $error("indirect address does not follow pointer");

    add_carry_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        alu_req.op == core_regs_pkg::ALU_ADD && !sfr_req.wr && !bit_req.wr
        |=> program_status_word.carry_flag ==
            (({1'b0, $past(primary_accumulator)}
            + {1'b0, $past(alu_req.operand)}) > 9'h0ff))
        else $error("carry wrong after add");

    sub_half_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        alu_req.op == core_regs_pkg::ALU_SUBB && !sfr_req.wr && !bit_req.wr
        |=> program_status_word.half_carry_flag ==
            ({1'b0, $past(primary_accumulator[3:0])} <
            {1'b0, $past(alu_req.operand[3:0])}
            + {4'h0, $past(program_status_word.carry_flag)}))
        else $error("half carry wrong after subtract");

    mul_result_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        alu_req.op == core_regs_pkg::ALU_MUL && !sfr_req.wr && !bit_req.wr
        |=> {secondary_accumulator, primary_accumulator} ==
            $past(primary_accumulator) * $past(alu_req.operand)
            && !program_status_word.carry_flag)
        else $error("multiply result or flags wrong");

    accum_read_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        sfr_req.rd && sfr_req.addr == core_regs_pkg::PRIMARY_ACCUMULATOR_ADDR
        |=> sfr_rdata == $past(primary_accumulator))
        else $error("accumulator read mismatch");

    status_layout_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        sfr_req.rd && sfr_req.addr == core_regs_pkg::PROGRAM_STATUS_WORD_ADDR
        |=> sfr_rdata == {$past(program_status_word), 3'h0})
        else $error("status word layout wrong");

    accum_bit_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        bit_req.wr && !sfr_req.wr
            && bit_req.addr[7:3]
                == core_regs_pkg::PRIMARY_ACCUMULATOR_ADDR[7:3]
            && alu_req.op == core_regs_pkg::ALU_NONE
        |=> primary_accumulator[$past(bit_req.addr[2:0])]
            == $past(bit_req.val))
        else $error("accumulator bit write lost");
endmodule

// ===== cpu_core_register_set_test.sv
module cpu_core_register_set_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    core_regs_pkg::sfr_req_t sfr_req = '0;
    core_regs_pkg::bit_req_t bit_req = '0;
    core_regs_pkg::alu_req_t alu_req = '0;
    logic push_req = 1'b0;
    logic pop_req = 1'b0;
    logic [7:0] sfr_rdata;
    logic [7:0] stack_top_pointer;
    logic [7:0] push_addr;
    logic [15:0] data_pointer_16;
    logic [15:0] flash_addr;
    logic [15:0] external_data_ram_addr;
    logic [7:0] primary_accumulator;
    logic [7:0] secondary_accumulator;
    core_regs_pkg::status_t program_status_word;
    int err_total = 0;
    int checks_done = 0;
    logic [7:0] v;

    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;

    cpu_core_register_set dut (
        .ref_clk(ref_clk),
        .reset(reset),
        .sfr_req(sfr_req),
        .bit_req(bit_req),
        .alu_req(alu_req),
        .push_req(push_req),
        .pop_req(pop_req),
        .sfr_rdata(sfr_rdata),
        .stack_top_pointer(stack_top_pointer),
        .push_addr(push_addr),
        .data_pointer_16(data_pointer_16),
        .flash_addr(flash_addr),
        .external_data_ram_addr(external_data_ram_addr),
        .primary_accumulator(primary_accumulator),
        .secondary_accumulator(secondary_accumulator),
        .program_status_word(program_status_word)
    );

    // Case equality so an unknown never counts as a match
    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string what);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Strobes rise and fall at falling edges, so each spans one rising edge
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        sfr_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(negedge ref_clk);
        sfr_req.wr = 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        sfr_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(negedge ref_clk);
        sfr_req.rd = 1'b0;
        d = sfr_rdata;
    endtask

    task automatic alu(input core_regs_pkg::alu_op_t op,
                       input logic [7:0] arg);
        @(negedge ref_clk);
        alu_req = '{op: op, operand: arg};
        @(negedge ref_clk);
        alu_req.op = core_regs_pkg::ALU_NONE;
    endtask

    task automatic test_reset_values();
        rd_reg(core_regs_pkg::STACK_TOP_POINTER_ADDR, v);
        check(v, 8'h07, "stack pointer reset");
        rd_reg(core_regs_pkg::DATA_POINTER_HIGH_ADDR, v);
        check(v, 8'h00, "pointer high reset");
        rd_reg(core_regs_pkg::PRIMARY_ACCUMULATOR_ADDR, v);
        check(v, 8'h00, "accumulator reset");
        rd_reg(core_regs_pkg::PROGRAM_STATUS_WORD_ADDR, v);
        check(v, 8'h00, "status reset");
        check(data_pointer_16, 16'h0000, "pointer reset");
    endtask

    // Pointer bytes are independent; address outputs trail by one cycle
    task automatic test_pointer();
        wr_reg(core_regs_pkg::PRIMARY_ACCUMULATOR_ADDR, 8'h0f);
        wr_reg(core_regs_pkg::DATA_POINTER_HIGH_ADDR, 8'h12);
        check(data_pointer_16, 16'h1200, "pointer high byte");
        wr_reg(core_regs_pkg::DATA_POINTER_LOW_ADDR, 8'h34);
        check(data_pointer_16, 16'h1234, "pointer both bytes");
        @(negedge ref_clk);
        check(external_data_ram_addr, 16'h1234, "ram address");
        check(flash_addr, 16'h1243, "flash address");
    endtask

    task automatic test_stack();
        @(negedge ref_clk);
        push_req = 1'b1;
        @(negedge ref_clk);
        check(stack_top_pointer, 8'h08, "first push");
        check(push_addr, 8'h08, "first push store");
        @(negedge ref_clk);
        push_req = 1'b0;
        check(push_addr, 8'h09, "back to back push");
        pop_req = 1'b1;
        @(negedge ref_clk);
        pop_req = 1'b0;
        check(stack_top_pointer, 8'h08, "pop");
        // Software write wins over a push in the same cycle
        sfr_req = '{addr: core_regs_pkg::STACK_TOP_POINTER_ADDR, wr: 1'b1,
                    rd: 1'b0, wdata: 8'h40};
        push_req = 1'b1;
        @(negedge ref_clk);
        sfr_req.wr = 1'b0;
        push_req = 1'b0;
        check(stack_top_pointer, 8'h40, "write beats push");
    endtask

    // Accumulator is 0x0f on entry; every operation kind appears once, add twice
    task automatic test_arith();
        alu(core_regs_pkg::ALU_ADD, 8'h01);
        check(primary_accumulator, 8'h10, "add result");
        check(program_status_word, 5'h08, "nibble carry");
        alu(core_regs_pkg::ALU_ADD, 8'hf0);
        check(program_status_word, 5'h10, "byte carry");
        alu(core_regs_pkg::ALU_SUBB, 8'h01);
        check(primary_accumulator, 8'hfe, "subtract result");
        rd_reg(core_regs_pkg::PROGRAM_STATUS_WORD_ADDR, v);
        check(v, 8'hc0, "borrow flags");
        alu(core_regs_pkg::ALU_ADDC, 8'h01);
        check(primary_accumulator, 8'h00, "add with carry");
        check(program_status_word, 5'h18, "carry chain flags");
        wr_reg(core_regs_pkg::PRIMARY_ACCUMULATOR_ADDR, 8'h10);
        alu(core_regs_pkg::ALU_MUL, 8'h20);
        check(secondary_accumulator, 8'h02, "product high");
        check(primary_accumulator, 8'h00, "product low");
        check(program_status_word, 5'h00, "multiply clears");
    endtask

    // Unmapped and unimplemented places, bit writes, status layout
    task automatic test_decode();
        wr_reg(8'h84, 8'h5a);
        rd_reg(8'h84, v);
        check(v, 8'h00, "unmapped read");
        wr_reg(core_regs_pkg::PROGRAM_STATUS_WORD_ADDR, 8'hff);
        rd_reg(core_regs_pkg::PROGRAM_STATUS_WORD_ADDR, v);
        check(v, 8'hf8, "status low bits");
        wr_reg(core_regs_pkg::PROGRAM_STATUS_WORD_ADDR, 8'h28);
        check(program_status_word, 5'h05, "user flag and bank");
        wr_reg(core_regs_pkg::SECONDARY_ACCUMULATOR_ADDR, 8'ha5);
        rd_reg(core_regs_pkg::SECONDARY_ACCUMULATOR_ADDR, v);
        check(v, 8'ha5, "second register");
        @(negedge ref_clk);
        bit_req = '{addr: 8'he3, wr: 1'b1, val: 1'b1};
        @(negedge ref_clk);
        bit_req.wr = 1'b0;
        check(primary_accumulator, 8'h08, "accumulator bit");
    endtask

    task automatic test_second_reset();
        @(negedge ref_clk);
        reset = 1'b1;
        repeat (2) @(negedge ref_clk);
        reset = 1'b0;
        check(stack_top_pointer, 8'h07, "stack pointer again");
        check(data_pointer_16, 16'h0000, "pointer again");
    endtask

    initial begin
        repeat (6) @(negedge ref_clk);
        reset = 1'b0;
        test_reset_values();
        test_pointer();
        test_stack();
        test_arith();
        test_decode();
        test_second_reset();
        give_verdict();
    end

    // Whole run is about 60 cycles; far beyond that means a hang
    initial begin
        #20000;
        err_total++;
        give_verdict();
    end
endmodule
